// *** rtl/uff_bit_timer.sv ***
// Bit-period timer: pulses once every period_i cycles after a restart.
// Assumes period_i is at least one and stable within a bit.
`timescale 1ns/1ps
`default_nettype none

module uff_bit_timer (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rstn_i,
	// Control
	input  wire logic                          restart_i,
	input  wire logic [uff_pkg::UFF_TMR_W-1:0] period_i,
	// Tick
	output logic                               tick_o
);

	uff_pkg::uff_tmr_st_t q;
	uff_pkg::uff_tmr_st_t d;

	assign tick_o = !restart_i && (q.cnt == period_i - 1'b1);

	always_comb begin
		d = q;
		if (restart_i || tick_o) begin
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

// *** rtl/uff_pkg.sv ***
// Shared constants and types of the UART frame-format and control block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package uff_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] UFF_ADDR_STATUS = 8'hf8;
	localparam logic [7:0] UFF_ADDR_DATA   = 8'hf9;
	localparam logic [7:0] UFF_ADDR_CTRL   = 8'hfb;

	// Control register: flush strobe at bit 7, configuration below it
	localparam int UFF_FLUSH_BIT = 7;

	// Status register bit positions
	localparam int UFF_ST_ACTIVE  = 0;
	localparam int UFF_ST_TX_BYTE = 1;
	localparam int UFF_ST_RX_BYTE = 2;
	localparam int UFF_ST_PAR_ERR = 3;
	localparam int UFF_ST_FRM_ERR = 4;

	// ----------------------------------------------------------------
	// Frame constants and timing
	// ----------------------------------------------------------------
	localparam int          UFF_TMR_W      = 16;
	localparam logic [2:0]  UFF_LAST_DATA  = 3'h7;
	localparam int          UFF_CLK_MHZ    = 100;
	localparam int          UFF_BIT_NS     = 160;
	localparam int          UFF_BIT_CYCLES = UFF_BIT_NS * UFF_CLK_MHZ / 1000;
	localparam logic        UFF_LINE_RESET = 1'b1;
	localparam logic        UFF_RTS_RESET  = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Field order mirrors control register bits 6 down to 0
	typedef struct packed {
		logic flow_enable;
		logic ninth_bit_value;
		logic nine_bit_enable;
		logic parity_enable;
		logic two_stop_bits_select;
		logic stop_level;
		logic start_level;
	} uff_cfg_t;

	localparam uff_cfg_t UFF_CFG_RESET = uff_cfg_t'(7'h02);

	typedef struct packed {
		logic framing_error_flag;
		logic parity_error_flag;
		logic rx_byte;
		logic tx_byte;
	} uff_flags_t;

	typedef enum logic [2:0] {
		UFF_IDLE,
		UFF_START,
		UFF_DATA,
		UFF_NINTH,
		UFF_STOP1,
		UFF_STOP2
	} uff_phase_t;

	typedef struct packed {
		logic [UFF_TMR_W-1:0] cnt;
	} uff_tmr_st_t;

	typedef struct packed {
		uff_phase_t ph;
		logic [7:0] shift;
		logic [2:0] cnt;
		logic       ninth;
		logic       line;
		logic       done;
		logic       pend;
		logic [7:0] pend_data;
	} uff_tx_st_t;

	typedef struct packed {
		uff_cfg_t   cfg;
		uff_flags_t flags;
		uff_phase_t rx_ph;
		logic [7:0] rx_shift;
		logic [2:0] rx_cnt;
		logic       rx_ninth;
		logic [7:0] rx_data;
		logic [7:0] rdata;
		logic       rts_n;
	} uff_top_st_t;

endpackage

// *** rtl/uff_top.sv ***
// UART frame-format and control block: registers, receiver, flow control.
// Assumes a one-cycle register port and a line synchronous to ref_clk_i.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module uff_top #(
	parameter int BIT_CYCLES = uff_pkg::UFF_BIT_CYCLES
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	// Register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	// Serial line
	input  wire logic       rxd_i,
	output logic            txd_o,
	// Flow control
	input  wire logic       cts_n_i,
	output logic            rts_n_o
);

	// ----------------------------------------------------------------
	// State and decode
	// ----------------------------------------------------------------
	uff_pkg::uff_top_st_t q;
	uff_pkg::uff_top_st_t d;

	logic                          wr_ctrl;
	logic                          wr_data;
	logic                          wr_stat;
	logic                          flush;
	logic                          rx_tick;
	logic [uff_pkg::UFF_TMR_W-1:0] rx_period;
	logic                          tx_busy;
	logic                          tx_done;
	logic                          parity_exp;
	logic [7:0]                    status;
	logic [7:0]                    ctrl_rd;

	assign wr_ctrl = wr_i && (addr_i == uff_pkg::UFF_ADDR_CTRL);
	assign wr_data = wr_i && (addr_i == uff_pkg::UFF_ADDR_DATA);
	assign wr_stat = wr_i && (addr_i == uff_pkg::UFF_ADDR_STATUS);
	// Writing zero to the flush position does nothing
	assign flush   = wr_ctrl && wdata_i[uff_pkg::UFF_FLUSH_BIT];

	// ----------------------------------------------------------------
	// Transmitter and receive bit timer
	// ----------------------------------------------------------------
	uff_tx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_tx (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.cfg_i     (q.cfg),
		.flush_i   (flush),
		.load_i    (wr_data),
		.data_i    (wdata_i),
		.cts_n_i   (cts_n_i),
		.busy_o    (tx_busy),
		.done_o    (tx_done),
		.txd_o     (txd_o)
	);

	// Start bit is checked at half a bit so data is sampled mid-bit
	assign rx_period = (q.rx_ph == uff_pkg::UFF_START)
	                 ? uff_pkg::UFF_TMR_W'(BIT_CYCLES / 2)
	                 : uff_pkg::UFF_TMR_W'(BIT_CYCLES);

	uff_bit_timer u_rx_timer (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.restart_i (q.rx_ph == uff_pkg::UFF_IDLE),
		.period_i  (rx_period),
		.tick_o    (rx_tick)
	);

	// Ones in data plus ninth bit must be even, or odd when odd sense chosen
	assign parity_exp = (^q.rx_shift) ^ q.cfg.ninth_bit_value;

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------
	always_comb begin
		status                           = '0;
		status[uff_pkg::UFF_ST_ACTIVE]   = tx_busy || (q.rx_ph != uff_pkg::UFF_IDLE);
		status[uff_pkg::UFF_ST_TX_BYTE]  = q.flags.tx_byte;
		status[uff_pkg::UFF_ST_RX_BYTE]  = q.flags.rx_byte;
		status[uff_pkg::UFF_ST_PAR_ERR]  = q.flags.parity_error_flag;
		status[uff_pkg::UFF_ST_FRM_ERR]  = q.flags.framing_error_flag;
		// Flush position has no storage, so it reads zero in every state
		ctrl_rd                          = '0;
		ctrl_rd[uff_pkg::UFF_FLUSH_BIT-1:0] = q.cfg;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d       = q;
		d.rdata = '0;

		// Register reads: data only in the cycle after the strobe
		if (rd_i) begin
			case (addr_i)
				uff_pkg::UFF_ADDR_CTRL:   d.rdata = ctrl_rd;
				uff_pkg::UFF_ADDR_DATA:   d.rdata = q.rx_data;
				uff_pkg::UFF_ADDR_STATUS: d.rdata = status;
				default:                  d.rdata = '0;
			endcase
		end

		if (wr_ctrl) begin
			d.cfg = uff_pkg::uff_cfg_t'(wdata_i[uff_pkg::UFF_FLUSH_BIT-1:0]);
		end

		// Status flags clear by writing one; a same-cycle event wins below
		if (wr_stat) begin
			if (wdata_i[uff_pkg::UFF_ST_TX_BYTE]) d.flags.tx_byte = 1'b0;
			if (wdata_i[uff_pkg::UFF_ST_RX_BYTE]) d.flags.rx_byte = 1'b0;
			if (wdata_i[uff_pkg::UFF_ST_PAR_ERR]) d.flags.parity_error_flag = 1'b0;
			if (wdata_i[uff_pkg::UFF_ST_FRM_ERR]) d.flags.framing_error_flag = 1'b0;
		end

		if (tx_done) begin
			d.flags.tx_byte = 1'b1;
		end

		// Receiver
		case (q.rx_ph)
			uff_pkg::UFF_IDLE: begin
				// Idle line sits at the opposite of the start level
				if (rxd_i == q.cfg.start_level) begin
					d.rx_ph = uff_pkg::UFF_START;
				end
			end
			uff_pkg::UFF_START: begin
				if (rx_tick) begin
					// A glitch shorter than half a bit is not a start bit
					if (rxd_i == q.cfg.start_level) begin
						d.rx_ph  = uff_pkg::UFF_DATA;
						d.rx_cnt = '0;
					end else begin
						d.rx_ph = uff_pkg::UFF_IDLE;
					end
				end
			end
			uff_pkg::UFF_DATA: begin
				if (rx_tick) begin
					d.rx_shift = {rxd_i, q.rx_shift[7:1]};
					d.rx_cnt   = q.rx_cnt + 1'b1;
					if (q.rx_cnt == uff_pkg::UFF_LAST_DATA) begin
						d.rx_ph = q.cfg.nine_bit_enable ? uff_pkg::UFF_NINTH
						                                : uff_pkg::UFF_STOP1;
					end
				end
			end
			uff_pkg::UFF_NINTH: begin
				if (rx_tick) begin
					d.rx_ninth = rxd_i;
					d.rx_ph    = uff_pkg::UFF_STOP1;
				end
			end
			uff_pkg::UFF_STOP1: begin
				if (rx_tick) begin
					// Byte is delivered at the first stop bit either way
					d.rx_data       = q.rx_shift;
					d.flags.rx_byte = 1'b1;
					if (rxd_i != q.cfg.stop_level) begin
						d.flags.framing_error_flag = 1'b1;
					end
					if (q.cfg.nine_bit_enable && q.cfg.parity_enable
					    && (q.rx_ninth != parity_exp)) begin
						d.flags.parity_error_flag = 1'b1;
					end
					d.rx_ph = q.cfg.two_stop_bits_select ? uff_pkg::UFF_STOP2
					                                     : uff_pkg::UFF_IDLE;
				end
			end
			uff_pkg::UFF_STOP2: begin
				if (rx_tick) begin
					// A bad second stop shows one bit after the byte
					if (rxd_i != q.cfg.stop_level) begin
						d.flags.framing_error_flag = 1'b1;
					end
					d.rx_ph = uff_pkg::UFF_IDLE;
				end
			end
			default: begin
				d.rx_ph = uff_pkg::UFF_IDLE;
			end
		endcase

		// Flush drops a half-received byte but leaves every flag alone
		if (flush) begin
			d.rx_ph    = uff_pkg::UFF_IDLE;
			d.rx_shift = '0;
			d.rx_cnt   = '0;
			d.flags    = q.flags;
			if (wr_stat) begin
				d.flags = q.flags;
			end
		end

		// Ready to receive only while flow control is on and no unread byte is waiting
		d.rts_n = !(d.cfg.flow_enable && !d.flags.rx_byte);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q       <= '0;
			q.cfg   <= uff_pkg::UFF_CFG_RESET;
			q.rts_n <= uff_pkg::UFF_RTS_RESET;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign rts_n_o = q.rts_n;

endmodule

`default_nettype wire

// *** rtl/uff_tx.sv ***
// Transmit framer: one holding byte, start/data/ninth/stop sequencing.
// Assumes cfg_i comes from the control register and tick_o from a timer.
`timescale 1ns/1ps
`default_nettype none

module uff_tx #(
	parameter int BIT_CYCLES = uff_pkg::UFF_BIT_CYCLES
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rstn_i,
	// Control
	input  wire uff_pkg::uff_cfg_t cfg_i,
	input  wire logic              flush_i,
	input  wire logic              load_i,
	input  wire logic [7:0]        data_i,
	input  wire logic              cts_n_i,
	// Status and line
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   txd_o
);

	uff_pkg::uff_tx_st_t q;
	uff_pkg::uff_tx_st_t d;
	logic                tick;
	logic                cts_ok;
	logic                ninth_calc;

	uff_bit_timer u_timer (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.restart_i (q.ph == uff_pkg::UFF_IDLE),
		.period_i  (uff_pkg::UFF_TMR_W'(BIT_CYCLES)),
		.tick_o    (tick)
	);

	// Without flow control the clear-to-send line is ignored
	assign cts_ok = !cfg_i.flow_enable || !cts_n_i;
	// Even sense: ninth bit makes the count of ones even; odd inverts it
	assign ninth_calc = cfg_i.parity_enable ? (^q.pend_data) ^ cfg_i.ninth_bit_value
	                                        : cfg_i.ninth_bit_value;
	assign busy_o = (q.ph != uff_pkg::UFF_IDLE) || q.pend;
	assign done_o = q.done;
	assign txd_o  = q.line;

	always_comb begin
		d      = q;
		d.done = 1'b0;
		case (q.ph)
			uff_pkg::UFF_IDLE: begin
				d.line = ~cfg_i.start_level;
				if (q.pend && cts_ok) begin
					d.ph    = uff_pkg::UFF_START;
					d.line  = cfg_i.start_level;
					d.shift = q.pend_data;
					d.ninth = ninth_calc;
					d.cnt   = '0;
					d.pend  = 1'b0;
				end
			end
			uff_pkg::UFF_START: begin
				if (tick) begin
					d.ph    = uff_pkg::UFF_DATA;
					d.line  = q.shift[0];
					d.shift = {1'b0, q.shift[7:1]};
				end
			end
			uff_pkg::UFF_DATA: begin
				if (tick) begin
					if (q.cnt == uff_pkg::UFF_LAST_DATA) begin
						if (cfg_i.nine_bit_enable) begin
							d.ph   = uff_pkg::UFF_NINTH;
							d.line = q.ninth;
						end else begin
							d.ph   = uff_pkg::UFF_STOP1;
							d.line = cfg_i.stop_level;
						end
					end else begin
						d.cnt   = q.cnt + 1'b1;
						d.line  = q.shift[0];
						d.shift = {1'b0, q.shift[7:1]};
					end
				end
			end
			uff_pkg::UFF_NINTH: begin
				if (tick) begin
					d.ph   = uff_pkg::UFF_STOP1;
					d.line = cfg_i.stop_level;
				end
			end
			uff_pkg::UFF_STOP1: begin
				if (tick) begin
					if (cfg_i.two_stop_bits_select) begin
						d.ph = uff_pkg::UFF_STOP2;
					end else begin
						d.ph   = uff_pkg::UFF_IDLE;
						d.line = ~cfg_i.start_level;
						d.done = 1'b1;
					end
				end
			end
			uff_pkg::UFF_STOP2: begin
				if (tick) begin
					d.ph   = uff_pkg::UFF_IDLE;
					d.line = ~cfg_i.start_level;
					d.done = 1'b1;
				end
			end
			default: begin
				d.ph = uff_pkg::UFF_IDLE;
			end
		endcase
		if (load_i) begin
			d.pend      = 1'b1;
			d.pend_data = data_i;
		end
		// Flush drops the frame and any waiting byte, flags stay as they are
		if (flush_i) begin
			d.ph   = uff_pkg::UFF_IDLE;
			d.pend = 1'b0;
			d.done = 1'b0;
			d.line = ~cfg_i.start_level;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q      <= '0;
			q.line <= uff_pkg::UFF_LINE_RESET;
		end else begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

// *** test/uart_frame_format_control_bench.sv ***
// Self-checking bench of the frame-control block against a remote transceiver.
// Assumes a short bit period of 8 clocks; frames are modelled in the bench.
`timescale 1ns/1ps
`default_nettype none

module uart_frame_format_control_bench;
	localparam int B = 8;
	logic       ref_clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic       rxd_i;
	logic       txd_o;
	logic       cts_n_i;
	logic       rts_n_o;
	logic [6:0] cfg = 7'h02;
	logic       hold = 1'b0;
	int         error_cnt = 0;
	int         comparisons = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	uff_top #(.BIT_CYCLES(B)) DUT (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
		.cts_n_i(cts_n_i), .rts_n_o(rts_n_o));
	uff_partner #(.B(B)) P (.clk_i(ref_clk_i), .cfg_i(cfg), .hold_i(hold),
		.txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));

	// --------------------------------------------------------------
	// Model, bus tasks and checks
	// --------------------------------------------------------------
	// Line bits after the start bit: data LSB first, ninth bit, stop bits
	function automatic logic [10:0] frm(input logic [6:0] c, input logic [7:0] d);
		int k;
		frm = {3'h0, d};
		k = 8;
		if (c[4]) begin
			frm[k] = c[3] ? (^d ^ c[5]) : c[5];
			k++;
		end
		frm[k] = c[1];
		if (c[2]) frm[k + 1] = c[1];
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// New control bits with a flush; the settle time drops false starts
	task automatic setcfg(input logic [6:0] c);
		cfg <= c;
		wreg(8'hfb, {1'b1, c});
		repeat (12 * B) @(posedge ref_clk_i);
		P.cap.delete();
	endtask

	task automatic wait_cap();
		int n;
		for (n = 0; n < 40 * B && P.cap.size() == 0; n++) @(posedge ref_clk_i);
		if (n == 40 * B) begin
			error_cnt++;
			wrap_up();
		end
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		logic [7:0]  d;
		logic [7:0]  v;
		logic [7:0]  s;
		logic [10:0] f;
		logic [6:0]  c;
		int          e;
		int          n;
		void'($urandom(32'hf0efb0d4));
		repeat (16) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		rreg(8'hfb, v);
		chk(v, 8'h02);
		rreg(8'h10, v);
		chk(v, 8'h00);
		for (int i = 0; i < 16; i++) begin
			c = {1'b0, 1'($urandom()), i[3], i[2], i[1], ~i[0], i[0]};
			setcfg(c);
			rreg(8'hfb, v);
			chk(v, {1'b0, c});
			d = 8'($urandom());
			wreg(8'hf9, d);
			wait_cap();
			chk(P.cap.pop_front(), frm(c, d));
			d = 8'($urandom());
			e = $urandom_range(2);
			f = frm(c, d);
			n = 9 + c[4] + c[2];
			if (e == 1 && c[4] && c[3]) f[8] = ~f[8];
			if (e == 2) f[n - 1] = ~f[n - 1];
			P.send(f, n);
			repeat (2 * B) @(posedge ref_clk_i);
			rreg(8'hf8, s);
			chk(s[4:1], {e == 2, e == 1 && c[4] && c[3], 2'b11});
			wreg(8'hfb, {1'b1, c});
			rreg(8'hf8, v);
			chk(v[4:1], s[4:1]);
			rreg(8'hf9, v);
			chk(v, d);
			wreg(8'hf8, 8'h1e);
			rreg(8'hf8, v);
			chk(v, 8'h00);
		end
		c = 7'h42;
		setcfg(c);
		chk(rts_n_o, 1'b0);
		hold <= 1'b1;
		wreg(8'hf9, 8'ha5);
		repeat (30 * B) @(posedge ref_clk_i);
		chk(P.cap.size(), 0);
		chk(txd_o, 1'b1);
		rreg(8'hf8, v);
		chk(v[0], 1'b1);
		hold <= 1'b0;
		wait_cap();
		chk(P.cap.pop_front(), frm(c, 8'ha5));
		P.send(frm(c, 8'h5a), 9);
		repeat (2 * B) @(posedge ref_clk_i);
		chk(rts_n_o, 1'b1);
		wreg(8'hf8, 8'h1e);
		wreg(8'hf9, 8'h3c);
		repeat (3 * B) @(posedge ref_clk_i);
		wreg(8'hfb, {1'b1, c});
		repeat (12 * B) @(posedge ref_clk_i);
		chk(txd_o, 1'b1);
		rreg(8'hf8, v);
		chk(v[1], 1'b0);
		wreg(8'hfb, 8'h02);
		repeat (3) @(posedge ref_clk_i);
		chk(rts_n_o, 1'b1);
		wrap_up();
	end
endmodule

`default_nettype wire

// *** test/uff_partner.sv ***
// Remote serial transceiver: decodes the transmit line, frames the receive line.
// Assumes the bench hands it the current control bits and the clear-to-send level.
`timescale 1ns/1ps
`default_nettype none

module uff_partner #(
	parameter int B = 8
) (
	// Clock and configuration
	input  wire logic       clk_i,
	input  wire logic [6:0] cfg_i,
	input  wire logic       hold_i,
	// Line and flow control
	input  wire logic       txd_i,
	output logic            rxd_o,
	output logic            cts_n_o
);
	logic [10:0] cap[$];
	logic [10:0] w;
	logic        drv = 1'b0;
	logic        bit_q = 1'b0;

	assign cts_n_o = hold_i;
	assign rxd_o = drv ? bit_q : !cfg_i[0];

	// --------------------------------------------------------------
	// Receive: mid-bit sampling after a start level is seen
	// --------------------------------------------------------------
	always begin
		@(posedge clk_i);
		if (txd_i === cfg_i[0]) begin
			w = 11'h000;
			repeat (B / 2) @(posedge clk_i);
			for (int k = 0; k < 9 + cfg_i[4] + cfg_i[2]; k++) begin
				repeat (B) @(posedge clk_i);
				w[k] = txd_i;
			end
			cap.push_back(w);
		end
	end

	// Send one frame of n bits after a start bit
	task automatic send(input logic [10:0] f, input int n);
		@(posedge clk_i);
		drv <= 1'b1;
		bit_q <= cfg_i[0];
		for (int k = 0; k < n; k++) begin
			repeat (B) @(posedge clk_i);
			bit_q <= f[k];
		end
		repeat (B) @(posedge clk_i);
		drv <= 1'b0;
	endtask
endmodule

`default_nettype wire

// *** test/uff_properties.sv ***
// Port-level checker of the frame-control block, bound into its top module.
// Assumes the package register map and the BIT_CYCLES of the instance.
`timescale 1ns/1ps
`default_nettype none

module uff_properties #(
	parameter int BIT_CYCLES = 16
) (
	// Clock and reset
	input wire logic       ref_clk_i,
	input wire logic       rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	// Line and flow control
	input wire logic       rxd_i,
	input wire logic       txd_o,
	input wire logic       cts_n_i,
	input wire logic       rts_n_o
);
	logic [6:0]  cfg_q;
	logic [15:0] run_q;
	logic [2:0]  age_q;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	// --------------------------------------------------------------
	// Shadow control bits; line-run and write-age counters
	// --------------------------------------------------------------
	// Age masks line steps caused by a control write (flush, new idle level)
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			cfg_q <= 7'h02;
			run_q <= 16'hffff;
			age_q <= 3'h7;
		end else begin
			if (wr_i && addr_i == 8'hfb) cfg_q <= wdata_i[6:0];
			age_q <= (wr_i && addr_i == 8'hfb) ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
			run_q <= $changed(txd_o) ? 16'h0001 : (run_q == 16'hffff ? run_q : run_q + 16'h1);
		end
	end

	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	flush_reads_zero_a: assert property (rd_i && addr_i == 8'hfb |=> !rdata_o[7])
		else $error("flush bit read back as one");
	cfg_readback_a: assert property (rd_i && addr_i == 8'hfb |=> rdata_o[6:0] == cfg_q)
		else $error("control bits read back wrong");
	flush_idle_a: assert property (wr_i && addr_i == 8'hfb && wdata_i[7]
		|-> ##[1:3] txd_o != cfg_q[0]) else $error("line not idle after flush");
	rts_off_a: assert property (!cfg_q[6] && !$past(cfg_q[6]) |-> rts_n_o)
		else $error("request to send low with flow off");
	bit_width_a: assert property ($changed(txd_o) && age_q == 3'h7
		|-> run_q >= 16'(BIT_CYCLES)) else $error("transmit bit shorter than a period");
	unmapped_zero_a: assert property (rd_i && !(addr_i inside {8'hf8, 8'hf9, 8'hfb})
		|=> rdata_o == 8'h00) else $error("unmapped read not zero");
	rdata_quiet_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	reset_levels_a: assert property ($rose(rstn_i) |-> txd_o && rts_n_o && rdata_o == 8'h00)
		else $error("outputs wrong after reset");
endmodule

bind uff_top uff_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
	.cts_n_i(cts_n_i), .rts_n_o(rts_n_o)
);

`default_nettype wire
